//--- flf_map.svh
`ifndef FLF_MAP_SVH
`define FLF_MAP_SVH

// ****************************************
// block read framing
// ****************************************
`define FLF_BYTE_COUNT 8'hff
`define FLF_LAST_SEQ 8'hff
`define FLF_PTR_BYTE 8'h00
`define FLF_TIME_FIRST 8'h01
`define FLF_TIME_LAST 8'h06
`define FLF_EXT_FIRST 8'h07
`define FLF_EXT_LAST 8'h2e
`define FLF_TELEM_FIRST 8'h2f
`define FLF_TELEM_LAST 8'hed
`define FLF_RESERVED_BYTE 8'h00

// ****************************************
// loop layout
// ****************************************
`define FLF_LOOP_LEN 40
`define FLF_LOOP_TOP 6'h27
`define FLF_GROUPS 10
`define FLF_GROUP_TOP 4'h9
`define FLF_GROUP_VIN 4'h2
`define FLF_GROUP_TEMP 4'h5
`define FLF_SLOT_LOW 2'h0
`define FLF_SLOT_HIGH 2'h1
`define FLF_SLOT_FLAGS 2'h2
`define FLF_SLOT_VENDOR 2'h3
`define FLF_TELEM_BYTES 191
`define FLF_RING_LOOPS 5

// ****************************************
// shared time base
// ****************************************
`define FLF_TIME_W 41
`define FLF_TICK_NS 200000
`define FLF_CLK_NS 100
`define FLF_TICK_CYCLES ((`FLF_TICK_NS + `FLF_CLK_NS - 1) / `FLF_CLK_NS)

`endif

//--- flf_pkg.sv
package flf_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [15:0] value;
    logic [7:0] flags;
    logic [7:0] vendor_flags;
  } flf_sample_t;

  typedef struct packed {
    logic [15:0] peak;
    logic [15:0] low;
  } flf_extreme_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } flf_byte_t;

  typedef enum logic [0:0] {
    FLF_IDLE,
    FLF_SEND
  } flf_state_t;

endpackage : flf_pkg

//--- flf_tick_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "flf_map.svh"

module flf_tick_counter #(
  parameter int TICK_CYCLES = `FLF_TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // count
  output logic [`FLF_TIME_W-1:0] shared_tick_counter
);

  localparam int DIV_W = $clog2(TICK_CYCLES + 1);

  generate
    if (TICK_CYCLES < 1) begin : g_bad
      $error("tick divider needs at least one cycle");
    end
  endgenerate

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [`FLF_TIME_W-1:0] count_r;
  logic [`FLF_TIME_W-1:0] count_nxt;

  // ****************************************
  // divider and counter
  // ****************************************
  always_comb begin
    div_nxt = div_r + 1'b1;
    count_nxt = count_r;
    if (div_r == DIV_W'(TICK_CYCLES - 1)) begin
      div_nxt = '0;
      count_nxt = count_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      div_r <= '0;
      count_r <= '0;
    end else begin
      div_r <= div_nxt;
      count_r <= count_nxt;
    end
  end

  assign shared_tick_counter = count_r;

endmodule : flf_tick_counter

`default_nettype wire

//--- flf_formatter.sv
`timescale 1ns/1ps
`default_nettype none
`include "flf_map.svh"

module flf_formatter #(
  parameter int LOOPS = `FLF_RING_LOOPS,
  parameter int TICK_CYCLES = `FLF_TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // conversion results
  input wire logic adc_done,
  input wire logic [3:0] adc_group,
  input wire flf_pkg::flf_sample_t adc_sample,
  input wire logic ram_lock,
  // fault capture
  input wire logic fault_capture,
  input wire flf_pkg::flf_extreme_t [`FLF_GROUPS-1:0] extremes,
  // block read stream
  input wire logic rd_start,
  input wire logic out_ready,
  output logic out_valid,
  output flf_pkg::flf_byte_t out_byte,
  output logic rd_busy
);

  localparam int SLOT_W = (LOOPS > 1) ? $clog2(LOOPS) : 1;
  localparam int RING_LEN = LOOPS * `FLF_LOOP_LEN;
  localparam int RING_W = $clog2(RING_LEN);

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (RING_LEN < `FLF_TELEM_BYTES) begin : g_bad_loops
      $error("ring too small for the telemetry area");
    end
  endgenerate

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [RING_W-1:0] ring_idx(input logic [SLOT_W-1:0] slot,
                                                  input logic [5:0] pos);
    ring_idx = RING_W'(slot * `FLF_LOOP_LEN + pos);
  endfunction : ring_idx

  function automatic logic [SLOT_W-1:0] slot_step(input logic [SLOT_W-1:0] slot,
                                                   input logic up);
    if (up) begin
      slot_step = (slot == SLOT_W'(LOOPS - 1)) ? '0 : SLOT_W'(slot + 1'b1);
    end else begin
      slot_step = (slot == '0) ? SLOT_W'(LOOPS - 1) : SLOT_W'(slot - 1'b1);
    end
  endfunction : slot_step

  // ****************************************
  // shared time base
  // ****************************************
  logic [`FLF_TIME_W-1:0] tick_now;

  flf_tick_counter #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .shared_tick_counter(tick_now)
  );

  // ****************************************
  // ring writer
  // ****************************************
  logic [7:0] ring_r [RING_LEN];
  logic [7:0] ring_nxt [RING_LEN];
  logic [SLOT_W-1:0] wslot_r;
  logic [SLOT_W-1:0] wslot_nxt;
  logic [5:0] wpos_r;
  logic [5:0] wpos_nxt;
  logic [3:0] wgrp_r;
  logic [3:0] wgrp_nxt;

  always_comb begin
    logic [SLOT_W-1:0] ws;
    logic [5:0] base;
    ring_nxt = ring_r;
    wslot_nxt = wslot_r;
    wpos_nxt = wpos_r;
    wgrp_nxt = wgrp_r;
    ws = wslot_r;
    base = 6'({adc_group, 2'b00});
    if (adc_done && !ram_lock && adc_group <= `FLF_GROUP_TOP) begin
      if (adc_group <= wgrp_r) begin
        ws = slot_step(wslot_r, 1'b1);
      end
      ring_nxt[ring_idx(ws, base + 6'(`FLF_SLOT_LOW))] = adc_sample.value[7:0];
      ring_nxt[ring_idx(ws, base + 6'(`FLF_SLOT_HIGH))] = adc_sample.value[15:8];
      ring_nxt[ring_idx(ws, base + 6'(`FLF_SLOT_FLAGS))] = adc_sample.flags;
      if (adc_group == `FLF_GROUP_VIN || adc_group == `FLF_GROUP_TEMP) begin
        ring_nxt[ring_idx(ws, base + 6'(`FLF_SLOT_VENDOR))] = `FLF_RESERVED_BYTE;
      end else begin
        ring_nxt[ring_idx(ws, base + 6'(`FLF_SLOT_VENDOR))] = adc_sample.vendor_flags;
      end
      wslot_nxt = ws;
      wpos_nxt = base + 6'(`FLF_SLOT_VENDOR);
      wgrp_nxt = adc_group;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ring_r <= '{default: 8'h00};
      wslot_r <= '0;
      wpos_r <= '0;
      wgrp_r <= `FLF_GROUP_TOP;
    end else begin
      ring_r <= ring_nxt;
      wslot_r <= wslot_nxt;
      wpos_r <= wpos_nxt;
      wgrp_r <= wgrp_nxt;
    end
  end

  // ****************************************
  // fault snapshot
  // ****************************************
  logic [7:0] snap_pos_r;
  logic [7:0] snap_pos_nxt;
  logic [SLOT_W-1:0] snap_slot_r;
  logic [SLOT_W-1:0] snap_slot_nxt;
  logic [`FLF_TIME_W-1:0] snap_time_r;
  logic [`FLF_TIME_W-1:0] snap_time_nxt;
  flf_pkg::flf_extreme_t [`FLF_GROUPS-1:0] snap_ext_r;
  flf_pkg::flf_extreme_t [`FLF_GROUPS-1:0] snap_ext_nxt;

  always_comb begin
    snap_pos_nxt = snap_pos_r;
    snap_slot_nxt = snap_slot_r;
    snap_time_nxt = snap_time_r;
    snap_ext_nxt = snap_ext_r;
    if (fault_capture) begin
      snap_pos_nxt = 8'(wpos_r);
      snap_slot_nxt = wslot_r;
      snap_time_nxt = tick_now;
      snap_ext_nxt = extremes;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      snap_pos_r <= '0;
      snap_slot_r <= '0;
      snap_time_r <= '0;
      snap_ext_r <= '0;
    end else begin
      snap_pos_r <= snap_pos_nxt;
      snap_slot_r <= snap_slot_nxt;
      snap_time_r <= snap_time_nxt;
      snap_ext_r <= snap_ext_nxt;
    end
  end

  // ****************************************
  // block read sequencer
  // ****************************************
  flf_pkg::flf_state_t state_r;
  flf_pkg::flf_state_t state_nxt;
  logic [7:0] seq_r;
  logic [7:0] seq_nxt;
  logic [5:0] rpos_r;
  logic [5:0] rpos_nxt;
  logic [SLOT_W-1:0] rslot_r;
  logic [SLOT_W-1:0] rslot_nxt;
  flf_pkg::flf_byte_t byte_r;
  flf_pkg::flf_byte_t byte_nxt;

  always_comb begin
    logic [7:0] didx;
    logic [7:0] eoff;
    logic [15:0] word;
    logic [47:0] time_ext;
    state_nxt = state_r;
    seq_nxt = seq_r;
    rpos_nxt = rpos_r;
    rslot_nxt = rslot_r;
    byte_nxt = byte_r;
    didx = seq_r;
    eoff = 8'(didx - `FLF_EXT_FIRST);
    word = eoff[1] ? snap_ext_r[eoff[7:2]].low : snap_ext_r[eoff[7:2]].peak;
    time_ext = 48'(snap_time_r);
    case (state_r)
      flf_pkg::FLF_IDLE: begin
        if (rd_start) begin
          state_nxt = flf_pkg::FLF_SEND;
          seq_nxt = '0;
          byte_nxt.data = `FLF_BYTE_COUNT;
          byte_nxt.last = 1'b0;
          rpos_nxt = snap_pos_r[5:0];
          rslot_nxt = snap_slot_r;
        end
      end
      flf_pkg::FLF_SEND: begin
        if (out_ready) begin
          if (seq_r == `FLF_LAST_SEQ) begin
            state_nxt = flf_pkg::FLF_IDLE;
          end else begin
            seq_nxt = seq_r + 1'b1;
            byte_nxt.last = (seq_r == 8'(`FLF_LAST_SEQ - 1'b1));
            if (didx == `FLF_PTR_BYTE) begin
              byte_nxt.data = snap_pos_r;
            end else if (didx <= `FLF_TIME_LAST) begin
              byte_nxt.data = time_ext[8*(didx-`FLF_TIME_FIRST) +: 8];
            end else if (didx <= `FLF_EXT_LAST) begin
              byte_nxt.data = eoff[0] ? word[15:8] : word[7:0];
            end else if (didx <= `FLF_TELEM_LAST) begin
              byte_nxt.data = ring_r[ring_idx(rslot_r, rpos_r)];
              if (rpos_r == '0) begin
                rpos_nxt = `FLF_LOOP_TOP;
                rslot_nxt = slot_step(rslot_r, 1'b0);
              end else begin
                rpos_nxt = rpos_r - 1'b1;
              end
            end else begin
              byte_nxt.data = `FLF_RESERVED_BYTE;
            end
          end
        end
      end
      default: begin
        state_nxt = flf_pkg::FLF_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= flf_pkg::FLF_IDLE;
      seq_r <= '0;
      rpos_r <= '0;
      rslot_r <= '0;
      byte_r <= '0;
    end else begin
      state_r <= state_nxt;
      seq_r <= seq_nxt;
      rpos_r <= rpos_nxt;
      rslot_r <= rslot_nxt;
      byte_r <= byte_nxt;
    end
  end

  assign out_valid = (state_r == flf_pkg::FLF_SEND);
  assign out_byte = byte_r;
  assign rd_busy = (state_r == flf_pkg::FLF_SEND);

endmodule : flf_formatter

`default_nettype wire

//--- flf_host.sv
`timescale 1ns/1ps
`default_nettype none
module flf_host (
  // clock
  input wire logic sys_clk,
  // stream
  input wire logic out_valid,
  input wire flf_pkg::flf_byte_t out_byte,
  output logic rd_start,
  output logic out_ready
);
  logic [7:0] got [256];
  int last_at;
  int seed = 43850;
  initial begin
    rd_start = 1'b0;
    out_ready = 1'b0;
  end
  // **********
  // block read, stalls at random when slow
  // **********
  task automatic rd(input bit slow);
    int n;
    int t;
    n = 0;
    t = 0;
    last_at = -1;
    rd_start <= 1'b1;
    out_ready <= 1'b1;
    @(posedge sys_clk);
    rd_start <= 1'b0;
    while (n < 256 && t < 4000) begin
      @(posedge sys_clk);
      t++;
      if (out_valid && out_ready) begin
        got[n] = out_byte.data;
        if (out_byte.last) last_at = n;
        n++;
      end
      out_ready <= !slow || $random(seed) % 3 == 0;
    end
    out_ready <= 1'b0;
  endtask : rd
endmodule : flf_host
`default_nettype wire

//--- flf_formatter_chk.sv
`timescale 1ns/1ps
`default_nettype none
module flf_formatter_chk #(
  parameter int LOOPS = 5,
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // stream
  input wire logic rd_start,
  input wire logic out_ready,
  input wire logic out_valid,
  input wire flf_pkg::flf_byte_t out_byte,
  input wire logic rd_busy
);
  // **********
  // accepted byte count
  // **********
  logic [8:0] acc_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn || !out_valid) begin
      acc_r <= 9'h000;
    end else if (out_ready) begin
      acc_r <= acc_r + 9'h001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  start_read_a: assert property (rd_start && !out_valid |=> out_valid && rd_busy)
    else $error("read not started");
  count_first_a: assert property ($rose(out_valid) |-> out_byte.data == 8'hff)
    else $error("first byte not the count");
  byte_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("byte changed while stalled");
  read_end_a: assert property (out_valid && out_ready && out_byte.last |=> !out_valid)
    else $error("read runs past last byte");
  read_len_a: assert property (out_valid && out_ready |-> out_byte.last == (acc_r == 9'h0ff))
    else $error("last flag on wrong byte");
  reserved_zero_a: assert property (out_valid && acc_r > 9'h0ee |-> out_byte.data == 8'h00)
    else $error("reserved byte not zero");
  ptr_range_a: assert property (out_valid && acc_r == 9'h001 |-> out_byte.data < 8'h28)
    else $error("position out of loop");
  time_top_a: assert property (out_valid && acc_r == 9'h007 |-> out_byte.data[7:1] == 7'h00)
    else $error("time top byte too wide");
endmodule : flf_formatter_chk
bind flf_formatter flf_formatter_chk #(.LOOPS(LOOPS), .TICK_CYCLES(TICK_CYCLES)) chk (
  .sys_clk(sys_clk), .rstn(rstn), .rd_start(rd_start), .out_ready(out_ready),
  .out_valid(out_valid), .out_byte(out_byte), .rd_busy(rd_busy));
`default_nettype wire

//--- flf_formatter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flf_formatter_bench;
  localparam int LP = 5;
  localparam int TK = 4;
  logic sys_clk = 0, rstn = 0, adc_done = 0, ram_lock = 0, fault_capture = 0;
  logic [3:0] adc_group = 4'h0;
  flf_pkg::flf_sample_t adc_sample = '0;
  flf_pkg::flf_extreme_t [9:0] extremes = '0;
  logic rd_start, out_ready, out_valid, rd_busy;
  flf_pkg::flf_byte_t out_byte;
  logic [7:0] ring [LP*40];
  logic [31:0] w;
  int slot, slot_s, wp, ptr_s, lastg, fails, n_tests, seed = 43850;
  longint tick_s, cyc;
  always #50 sys_clk = ~sys_clk;
  flf_formatter #(.LOOPS(LP), .TICK_CYCLES(TK)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .adc_done(adc_done), .adc_group(adc_group),
    .adc_sample(adc_sample), .ram_lock(ram_lock), .fault_capture(fault_capture),
    .extremes(extremes), .rd_start(rd_start), .out_ready(out_ready),
    .out_valid(out_valid), .out_byte(out_byte), .rd_busy(rd_busy));
  flf_host host (.sys_clk(sys_clk), .out_valid(out_valid), .out_byte(out_byte),
    .rd_start(rd_start), .out_ready(out_ready));
  // **********
  // ring model
  // **********
  always @(posedge sys_clk) begin
    w = {adc_sample.vendor_flags, adc_sample.flags, adc_sample.value};
    if (!rstn) begin
      slot = 0; wp = 0; lastg = 15; ptr_s = 0; slot_s = 0;
      ring = '{default: 8'h00};
      cyc = 0;
      tick_s = 0;
    end else begin
      if (fault_capture) begin ptr_s = wp; slot_s = slot; tick_s = cyc / TK; end
      cyc++;
      if (adc_done && !ram_lock && adc_group <= 4'h9) begin
        if (adc_group <= lastg) slot = (slot + 1) % LP;
        lastg = adc_group;
        wp = 4 * adc_group + 3;
        for (int k = 0; k < 4; k++) ring[slot * 40 + 4 * adc_group + k] =
          (k == 3 && (adc_group == 4'h2 || adc_group == 4'h5)) ? 8'h00 : 8'(w >> (8 * k));
      end
    end
  end
  function automatic logic [7:0] exp_byte(input int i);
    int g;
    g = (i - 7) / 4;
    if (i == 0) return 8'(ptr_s);
    if (i < 7) return 8'(tick_s >> (8 * (i - 1)));
    if (i < 47) return 8'({extremes[g].low, extremes[g].peak} >> (8 * ((i - 7) % 4)));
    if (i < 238) return ring[(slot_s * 40 + ptr_s - (i - 47) + LP * 40) % (LP * 40)];
    return 8'h00;
  endfunction : exp_byte
  task automatic cmp(input string nm, input logic [8:0] exp, input logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic run(input bit early, input bit slow);
    rstn <= 1'b0;
    ram_lock <= 1'b0;
    for (int k = 0; k < 10; k++) extremes[k] <= $random(seed);
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    fault_capture <= early;
    @(posedge sys_clk);
    fault_capture <= 1'b0;
    repeat (80) begin
      adc_done <= 1'($random(seed));
      adc_group <= 4'({$random(seed)} % 12);
      adc_sample <= $random(seed);
      ram_lock <= {$random(seed)} % 6 == 0;
      @(posedge sys_clk);
    end
    fault_capture <= !early;
    adc_done <= 1'b0;
    @(posedge sys_clk);
    fault_capture <= 1'b0;
    ram_lock <= 1'b1;
    @(posedge sys_clk);
    host.rd(slow);
    cmp("count", 9'h0ff, {1'b0, host.got[0]});
    cmp("last", 9'h0ff, 9'(host.last_at));
    for (int i = 0; i < 47; i++)
      cmp("head", {1'b0, exp_byte(i)}, {1'b0, host.got[i + 1]});
    for (int i = 47; i < 238; i++)
      cmp("ring", {1'b0, exp_byte(i)}, {1'b0, host.got[i + 1]});
    for (int i = 238; i < 255; i++)
      cmp("pad", {1'b0, exp_byte(i)}, {1'b0, host.got[i + 1]});
    $display("run early %0d slow %0d done", early, slow);
  endtask : run
  initial begin
    run(1'b1, 1'b1);
    run(1'b0, 1'b0);
    run(1'b1, 1'b0);
    finish_test;
  end
  initial begin
    #2000000;
    fails++;
    finish_test;
  end
endmodule : flf_formatter_bench
`default_nettype wire
